// ---- logic/lsir_pkg.sv ----
`default_nettype none
package lsir_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_RT_STATUS_1    = 8'h56;
    localparam logic [7:0] ADDR_RT_STATUS_2    = 8'h57;
    localparam logic [7:0] ADDR_LATCHED_STATE  = 8'h59;
    localparam logic [7:0] ADDR_LATCHED_LIMIT  = 8'h5a;
    localparam logic [7:0] ADDR_STATE_IRQ_EN   = 8'h5b;
    localparam logic [7:0] ADDR_LIMIT_IRQ_EN   = 8'h5c;
    localparam logic [7:0] ADDR_OFFSET_WORD_A_BYTE0     = 8'h65;
    localparam logic [7:0] ADDR_OFFSET_WORD_A_BYTE1     = 8'h66;
    localparam logic [7:0] ADDR_OFFSET_WORD_A_BYTE2     = 8'h67;
    localparam logic [7:0] ADDR_OFFSET_WORD_A_BYTE3     = 8'h68;
    localparam logic [7:0] ADDR_PHASE_BYTE0    = 8'h7d;
    localparam logic [7:0] ADDR_PHASE_BYTE1    = 8'h7e;
    localparam logic [7:0] ADDR_PHASE_BYTE2    = 8'h7f;
    localparam logic [7:0] ADDR_PHASE_BYTE3    = 8'h80;

    // Bit positions inside the byte registers
    localparam int BIT_LOSS_OF_LOCK = 5;
    localparam int BIT_TRACKING     = 4;
    localparam int BIT_HOLD         = 3;
    localparam int BIT_OFFSET_WORD_A_LIMIT   = 2;
    localparam int BIT_WONT_RUN     = 4;

    // Index of each change source in the internal 4-bit vectors
    localparam int IDX_HOLD  = 0;
    localparam int IDX_TRK   = 1;
    localparam int IDX_LOL   = 2;
    localparam int IDX_OFFSET_WORD_A_LIMIT_FLAG  = 3;
    localparam int NUM_SRC   = 4;

    // Values after reset
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [3:0]  RESET_VEC4 = 4'h0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // State reported by the loop core
    typedef enum logic [1:0] {
        LSIR_FREERUN         = 2'b00,
        LSIR_HOLD            = 2'b01,
        LSIR_TRACK_LOCKED    = 2'b10,
        LSIR_TRACK_UNLOCKED  = 2'b11
    } lsir_loop_state_e;

endpackage
`default_nettype wire

// ---- logic/lsir_loop_status_regs.sv ----
// Functional notes
// - Wrong firmware sets won't-run, forces free-run until reset
// - Frequency-limit flag follows loop limit condition
// - Loss-of-lock change sets latched bit 5
// - Tracking change sets latched bit 4
// - Hold change sets latched bit 3
// - Frequency-limit change sets bit 2 at 5Ah
// - Writing one clears latched flag; zero keeps
// - Enables 5,4,3 gate state flags to summary
// - Enable bit 2 gates limit flag to summary
// - Offset word bytes at 65h to 68h
// - Offset word read-only two's-complement tuning offset
// - Phase word bytes at 7Dh to 80h
// - Phase word unit is 2^-10 ns
// - Positive phase means input leads feedback
// - Loss-of-lock bit meaningful only while tracking
// - Hold bit meaningful only while not tracking
`timescale 1ns/1ps
`default_nettype none
module lsir_loop_status_regs (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic        wr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        rd_in,
    input  wire logic [1:0]  loop_state_in,
    input  wire logic        at_limit_in,
    input  wire logic        firmware_mismatch_in,
    input  wire logic [31:0] offset_word_in,
    input  wire logic [31:0] phase_word_in,
    output var  logic [7:0]  rdata_out,
    output var  logic        rd_valid_out,
    output var  logic        loop_summary_irq_status_out,
    output var  logic        wont_run_flag_out,
    output var  logic        offset_word_a_limit_flag_out,
    output var  logic        loss_of_lock_flag_out,
    output var  logic        tracking_flag_out,
    output var  logic        hold_state_flag_out
);

    // Byte n of a 32-bit word
    function automatic logic [7:0] word_byte(input logic [31:0] w,
                                             input logic [1:0]  n);
        word_byte = w[8*n +: 8];
    endfunction

    lsir_pkg::lsir_loop_state_e state;
    logic [3:0]                 rt;
    logic [3:0]                 prev_rt;
    logic [3:0]                 change;
    logic [3:0]                 latched;
    logic [3:0]                 irq_en;
    logic [3:0]                 clr;
    logic [31:0]                offset_word_a_snap;
    logic [31:0]                phase_snap;
    logic [7:0]                 next_rdata;
    logic                       wr_state;
    logic                       wr_limit;
    logic                       rd_freq0;
    logic                       rd_phase0;

    assign state     = lsir_pkg::lsir_loop_state_e'(loop_state_in);
    assign wr_state  = wr_in && (addr_in == lsir_pkg::ADDR_LATCHED_STATE);
    assign wr_limit  = wr_in && (addr_in == lsir_pkg::ADDR_LATCHED_LIMIT);
    assign rd_freq0  = rd_in && (addr_in == lsir_pkg::ADDR_OFFSET_WORD_A_BYTE0);
    assign rd_phase0 = rd_in && (addr_in == lsir_pkg::ADDR_PHASE_BYTE0);

    // Won't-run latch, sticky until reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wont_run_flag_out <= 1'b0;
        end else if (firmware_mismatch_in) begin
            wont_run_flag_out <= 1'b1;
        end
    end

    // Real-time status bits; won't-run pins the loop in free-run
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rt <= lsir_pkg::RESET_VEC4;
        end else begin
            rt[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG] <= at_limit_in;
            if (wont_run_flag_out || firmware_mismatch_in) begin
                rt[lsir_pkg::IDX_TRK]  <= 1'b0;
                rt[lsir_pkg::IDX_LOL]  <= 1'b0;
                rt[lsir_pkg::IDX_HOLD] <= 1'b0;
            end else begin
                unique case (state)
                    lsir_pkg::LSIR_FREERUN: begin
                        rt[lsir_pkg::IDX_TRK]  <= 1'b0;
                        rt[lsir_pkg::IDX_LOL]  <= 1'b0;
                        rt[lsir_pkg::IDX_HOLD] <= 1'b0;
                    end
                    lsir_pkg::LSIR_HOLD: begin
                        rt[lsir_pkg::IDX_TRK]  <= 1'b0;
                        rt[lsir_pkg::IDX_LOL]  <= 1'b0;
                        rt[lsir_pkg::IDX_HOLD] <= 1'b1;
                    end
                    lsir_pkg::LSIR_TRACK_LOCKED: begin
                        rt[lsir_pkg::IDX_TRK]  <= 1'b1;
                        rt[lsir_pkg::IDX_LOL]  <= 1'b0;
                        rt[lsir_pkg::IDX_HOLD] <= 1'b0;
                    end
                    lsir_pkg::LSIR_TRACK_UNLOCKED: begin
                        rt[lsir_pkg::IDX_TRK]  <= 1'b1;
                        rt[lsir_pkg::IDX_LOL]  <= 1'b1;
                        rt[lsir_pkg::IDX_HOLD] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Real-time outputs
    assign offset_word_a_limit_flag_out   = rt[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG];
    assign loss_of_lock_flag_out = rt[lsir_pkg::IDX_LOL];
    assign tracking_flag_out     = rt[lsir_pkg::IDX_TRK];
    assign hold_state_flag_out   = rt[lsir_pkg::IDX_HOLD];

    // Previous real-time bits for edge detection
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_rt <= lsir_pkg::RESET_VEC4;
        end else begin
            prev_rt <= rt;
        end
    end

    // Clear strobes from write-one-to-clear accesses
    assign clr[lsir_pkg::IDX_HOLD] = wr_state
                                     && wdata_in[lsir_pkg::BIT_HOLD];
    assign clr[lsir_pkg::IDX_TRK]  = wr_state
                                     && wdata_in[lsir_pkg::BIT_TRACKING];
    assign clr[lsir_pkg::IDX_LOL]  = wr_state
                                     && wdata_in[lsir_pkg::BIT_LOSS_OF_LOCK];
    assign clr[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG] = wr_limit
                                     && wdata_in[lsir_pkg::BIT_OFFSET_WORD_A_LIMIT];

    // Latched change flags; a change in the clear cycle wins
    generate
        for (genvar i = 0; i < lsir_pkg::NUM_SRC; i++) begin : g_latch
            assign change[i] = rt[i] ^ prev_rt[i];
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    latched[i] <= 1'b0;
                end else if (change[i]) begin
                    latched[i] <= 1'b1;
                end else if (clr[i]) begin
                    latched[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt enable registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_en <= lsir_pkg::RESET_VEC4;
        end else if (wr_in) begin
            if (addr_in == lsir_pkg::ADDR_STATE_IRQ_EN) begin
                irq_en[lsir_pkg::IDX_LOL]  <=
                    wdata_in[lsir_pkg::BIT_LOSS_OF_LOCK];
                irq_en[lsir_pkg::IDX_TRK]  <=
                    wdata_in[lsir_pkg::BIT_TRACKING];
                irq_en[lsir_pkg::IDX_HOLD] <=
                    wdata_in[lsir_pkg::BIT_HOLD];
            end
            if (addr_in == lsir_pkg::ADDR_LIMIT_IRQ_EN) begin
                irq_en[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG] <=
                    wdata_in[lsir_pkg::BIT_OFFSET_WORD_A_LIMIT];
            end
        end
    end

    // Loop summary interrupt status
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            loop_summary_irq_status_out <= 1'b0;
        end else begin
            loop_summary_irq_status_out <= |(latched & irq_en);
        end
    end

    // Snapshots taken when the low byte is read
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            offset_word_a_snap <= lsir_pkg::RESET_WORD;
        end else if (rd_freq0) begin
            offset_word_a_snap <= offset_word_in;
        end
    end

    // Phase word in 2^-10 ns steps, positive when input leads
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_snap <= lsir_pkg::RESET_WORD;
        end else if (rd_phase0) begin
            phase_snap <= phase_word_in;
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        next_rdata = lsir_pkg::RESET_BYTE;
        unique case (addr_in)
            lsir_pkg::ADDR_RT_STATUS_1: begin
                next_rdata[lsir_pkg::BIT_LOSS_OF_LOCK] = rt[lsir_pkg::IDX_LOL];
                next_rdata[lsir_pkg::BIT_TRACKING]     = rt[lsir_pkg::IDX_TRK];
                next_rdata[lsir_pkg::BIT_HOLD]         = rt[lsir_pkg::IDX_HOLD];
            end
            lsir_pkg::ADDR_RT_STATUS_2: begin
                next_rdata[lsir_pkg::BIT_WONT_RUN]   = wont_run_flag_out;
                next_rdata[lsir_pkg::BIT_OFFSET_WORD_A_LIMIT] = rt[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG];
            end
            lsir_pkg::ADDR_LATCHED_STATE: begin
                next_rdata[lsir_pkg::BIT_LOSS_OF_LOCK] =
                    latched[lsir_pkg::IDX_LOL];
                next_rdata[lsir_pkg::BIT_TRACKING] =
                    latched[lsir_pkg::IDX_TRK];
                next_rdata[lsir_pkg::BIT_HOLD] =
                    latched[lsir_pkg::IDX_HOLD];
            end
            lsir_pkg::ADDR_LATCHED_LIMIT: begin
                next_rdata[lsir_pkg::BIT_OFFSET_WORD_A_LIMIT] =
                    latched[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG];
            end
            lsir_pkg::ADDR_STATE_IRQ_EN: begin
                next_rdata[lsir_pkg::BIT_LOSS_OF_LOCK] =
                    irq_en[lsir_pkg::IDX_LOL];
                next_rdata[lsir_pkg::BIT_TRACKING] =
                    irq_en[lsir_pkg::IDX_TRK];
                next_rdata[lsir_pkg::BIT_HOLD] =
                    irq_en[lsir_pkg::IDX_HOLD];
            end
            lsir_pkg::ADDR_LIMIT_IRQ_EN: begin
                next_rdata[lsir_pkg::BIT_OFFSET_WORD_A_LIMIT] =
                    irq_en[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG];
            end
            lsir_pkg::ADDR_OFFSET_WORD_A_BYTE0:
                next_rdata = word_byte(offset_word_in, 2'd0);
            lsir_pkg::ADDR_OFFSET_WORD_A_BYTE1:
                next_rdata = word_byte(offset_word_a_snap, 2'd1);
            lsir_pkg::ADDR_OFFSET_WORD_A_BYTE2:
                next_rdata = word_byte(offset_word_a_snap, 2'd2);
            lsir_pkg::ADDR_OFFSET_WORD_A_BYTE3:
                next_rdata = word_byte(offset_word_a_snap, 2'd3);
            lsir_pkg::ADDR_PHASE_BYTE0:
                next_rdata = word_byte(phase_word_in, 2'd0);
            lsir_pkg::ADDR_PHASE_BYTE1:
                next_rdata = word_byte(phase_snap, 2'd1);
            lsir_pkg::ADDR_PHASE_BYTE2:
                next_rdata = word_byte(phase_snap, 2'd2);
            lsir_pkg::ADDR_PHASE_BYTE3:
                next_rdata = word_byte(phase_snap, 2'd3);
            default: next_rdata = lsir_pkg::RESET_BYTE;
        endcase
    end

    // Registered read data, one cycle after the request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out    <= lsir_pkg::RESET_BYTE;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_in;
            if (rd_in) begin
                rdata_out <= next_rdata;
            end
        end
    end

    // Sequences used by the checks
    sequence s_lol_edge;
        $changed(rt[lsir_pkg::IDX_LOL]);
    endsequence

    sequence s_offset_word_a_low_read;
        rd_in && addr_in == lsir_pkg::ADDR_OFFSET_WORD_A_BYTE0;
    endsequence

    sequence s_offset_word_a_top_read;
        rd_in && addr_in == lsir_pkg::ADDR_OFFSET_WORD_A_BYTE3 && !rd_freq0;
    endsequence

    wont_run_sticky_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        firmware_mismatch_in |=> wont_run_flag_out [*8])
        else $error("won't-run flag did not stay set");

    wont_run_freerun_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        wont_run_flag_out |=> !tracking_flag_out && !hold_state_flag_out)
        else $error("loop not held in free-run");

    offset_word_a_limit_follow_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ##1 offset_word_a_limit_flag_out == $past(at_limit_in))
        else $error("frequency-limit flag does not follow the loop");

    lol_change_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_lol_edge |=> latched[lsir_pkg::IDX_LOL])
        else $error("loss-of-lock change not latched");

    trk_change_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(tracking_flag_out) || $fell(tracking_flag_out)
        |=> latched[lsir_pkg::IDX_TRK])
        else $error("tracking change not latched");

    hold_change_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $changed(hold_state_flag_out) |=> latched[lsir_pkg::IDX_HOLD])
        else $error("hold change not latched");

    limit_change_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $changed(offset_word_a_limit_flag_out) |=> latched[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG])
        else $error("frequency-limit change not latched");

    w1c_clear_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        wr_state && wdata_in[lsir_pkg::BIT_TRACKING]
        && !change[lsir_pkg::IDX_TRK] |=> !latched[lsir_pkg::IDX_TRK])
        else $error("write of one did not clear flag");

    w0_keep_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        latched[lsir_pkg::IDX_LOL] && !(wr_state
        && wdata_in[lsir_pkg::BIT_LOSS_OF_LOCK])
        |=> latched[lsir_pkg::IDX_LOL])
        else $error("flag cleared without a written one");

    summary_set_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        latched[lsir_pkg::IDX_HOLD] && irq_en[lsir_pkg::IDX_HOLD]
        |=> loop_summary_irq_status_out)
        else $error("enabled hold flag did not raise summary");

    summary_limit_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        latched[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG] && irq_en[lsir_pkg::IDX_OFFSET_WORD_A_LIMIT_FLAG]
        |=> loop_summary_irq_status_out)
        else $error("enabled limit flag did not raise summary");

    summary_fall_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (latched & irq_en) == 4'h0 |=> !loop_summary_irq_status_out)
        else $error("summary high with no enabled flag");

    offset_word_a_snapshot_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_offset_word_a_low_read ##1 s_offset_word_a_top_read
        |=> rdata_out == $past(offset_word_in[31:24], 2))
        else $error("offset top byte not from snapshot");

    phase_low_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        rd_phase0 |=> rd_valid_out && rdata_out == $past(phase_word_in[7:0]))
        else $error("phase low byte wrong");

    offset_ro_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        wr_in && !rd_freq0 |=> $stable(offset_word_a_snap))
        else $error("offset word changed by a write");

endmodule
`default_nettype wire

// ---- sim/loop_status_irq_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module loop_status_irq_regs_test;
    logic        clk_in               = 1'b0;
    logic        rst_in               = 1'b1;
    logic [7:0]  addr_in              = 8'h00;
    logic        wr_in                = 1'b0;
    logic [7:0]  wdata_in             = 8'h00;
    logic        rd_in                = 1'b0;
    logic [1:0]  loop_state_in        = 2'h0;
    logic        at_limit_in          = 1'b0;
    logic        firmware_mismatch_in = 1'b0;
    logic [31:0] offset_word_in       = 32'h0;
    logic [31:0] phase_word_in        = 32'h0;
    logic [7:0]  rdata_out;
    logic        rd_valid_out;
    logic        loop_summary_irq_status_out;
    logic        wont_run_flag_out;
    logic        offset_word_a_limit_flag_out;
    logic        loss_of_lock_flag_out;
    logic        tracking_flag_out;
    logic        hold_state_flag_out;
    int          n_mismatch           = 0;
    int          n_tests              = 0;
    logic [31:0] seed                 = 32'h4f38;
    logic [7:0]  lat1                 = 8'h00;
    logic [7:0]  lat2                 = 8'h00;
    logic [7:0]  en1                  = 8'h00;
    logic [7:0]  en2                  = 8'h00;
    logic [1:0]  cur                  = 2'h0;
    logic        lim                  = 1'b0;
    logic [7:0]  rv;

    lsir_loop_status_regs dut (
        .clk_in                      (clk_in),
        .rst_in                      (rst_in),
        .addr_in                     (addr_in),
        .wr_in                       (wr_in),
        .wdata_in                    (wdata_in),
        .rd_in                       (rd_in),
        .loop_state_in               (loop_state_in),
        .at_limit_in                 (at_limit_in),
        .firmware_mismatch_in        (firmware_mismatch_in),
        .offset_word_in              (offset_word_in),
        .phase_word_in               (phase_word_in),
        .rdata_out                   (rdata_out),
        .rd_valid_out                (rd_valid_out),
        .loop_summary_irq_status_out (loop_summary_irq_status_out),
        .wont_run_flag_out           (wont_run_flag_out),
        .offset_word_a_limit_flag_out         (offset_word_a_limit_flag_out),
        .loss_of_lock_flag_out       (loss_of_lock_flag_out),
        .tracking_flag_out           (tracking_flag_out),
        .hold_state_flag_out         (hold_state_flag_out)
    );

    // Free-running 100 MHz clock
    always #5 clk_in = ~clk_in;

    // Pseudo-random source, fixed start value
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Real-time state bits at their latched positions 5, 4, 3
    function automatic logic [7:0] rt_bits(input logic [1:0] s);
        return {2'b00, s == 2'b11, s[1], s == 2'b01, 3'b000};
    endfunction

    // Summary: any latched flag whose enable is set
    function automatic logic sum_exp();
        return (|(lat1 & en1)) | (|(lat2 & en2));
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_in  = a;
        wdata_in = d;
        wr_in    = 1'b1;
        @(negedge clk_in);
        wr_in    = 1'b0;
    endtask

    // One-cycle read strobe, data valid from the taking edge, sampled at the next falling edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_in = a;
        rd_in   = 1'b1;
        @(negedge clk_in);
        rd_in   = 1'b0;
        check(rd_valid_out, 1'b1, "read valid");
        d = rdata_out;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a, rv);
        check(rv, e, "read data");
    endtask

    // Move the loop state and follow the latched flags
    task automatic set_state(input logic [1:0] s);
        lat1 |= rt_bits(cur) ^ rt_bits(s);
        cur = s;
        @(negedge clk_in);
        loop_state_in = s;
        cycles(3);
        check(loss_of_lock_flag_out, s == 2'b11, "lol");
        check(tracking_flag_out, s[1], "tracking");
        check(hold_state_flag_out, s == 2'b01, "hold");
        check(loop_summary_irq_status_out, sum_exp(), "summary");
        rd_chk(8'h59, lat1);
        rd_chk(8'h56, rt_bits(s));
    endtask

    task automatic set_lim(input logic l);
        lat2 |= {5'b0, lim ^ l, 2'b0};
        lim = l;
        @(negedge clk_in);
        at_limit_in = l;
        cycles(3);
        check(offset_word_a_limit_flag_out, l, "limit flag");
        check(loop_summary_irq_status_out, sum_exp(), "summary");
        rd_chk(8'h5a, lat2);
    endtask

    task automatic clear(input logic [7:0] w1, input logic [7:0] w2);
        wr_reg(8'h59, w1);
        wr_reg(8'h5a, w2);
        lat1 &= ~w1;
        lat2 &= ~w2;
        cycles(2);
        check(loop_summary_irq_status_out, sum_exp(), "summary");
        rd_chk(8'h59, lat1);
        rd_chk(8'h5a, lat2);
    endtask

    task automatic set_en(input logic [7:0] e1, input logic [7:0] e2);
        wr_reg(8'h5b, e1);
        wr_reg(8'h5c, e2);
        en1 = e1;
        en2 = e2;
        cycles(2);
        check(loop_summary_irq_status_out, sum_exp(), "summary");
        rd_chk(8'h5b, e1);
        rd_chk(8'h5c, e2);
    endtask

    // Low byte read freezes the word; upper bytes come from the snapshot
    task automatic snap(input logic ph);
        logic [31:0] w;
        logic [31:0] got;
        logic [7:0]  b;
        seed = lfsr(seed);
        w = seed;
        b = ph ? 8'h7d : 8'h65;
        @(negedge clk_in);
        if (ph) phase_word_in = w;
        else offset_word_in = w;
        rd_chk(b, w[7:0]);
        got[7:0] = rv;
        @(negedge clk_in);
        if (ph) phase_word_in = ~w;
        else offset_word_in = ~w;
        for (int i = 1; i < 4; i++) begin
            rd_chk(b + 8'(i), w[8*i +: 8]);
            got[8*i +: 8] = rv;
        end
        check(got, w, "whole word");
        // Low and top reads back to back, strobe held high between them
        seed = lfsr(seed);
        w = seed;
        @(negedge clk_in);
        if (ph) phase_word_in = w;
        else offset_word_in = w;
        addr_in = b;
        rd_in   = 1'b1;
        @(negedge clk_in);
        check(rd_valid_out, 1'b1, "pair low valid");
        check(rdata_out, w[7:0], "pair low");
        if (ph) phase_word_in = ~w;
        else offset_word_in = ~w;
        addr_in = b + 8'h03;
        @(negedge clk_in);
        rd_in = 1'b0;
        check(rd_valid_out, 1'b1, "pair top valid");
        check(rdata_out, w[31:24], "pair top");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #500000;
        n_mismatch++;
        $display("ERROR %0t run limit reached", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [7:0] regs [12];
        regs = '{8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h65, 8'h66, 8'h67, 8'h68,
                 8'h7d, 8'h7e, 8'h7f, 8'h80};
        cycles(10);
        rst_in = 1'b0;
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        rd_chk(8'h90, 8'h00);
        wr_reg(8'h66, 8'hff);
        rd_chk(8'h66, 8'h00);
        $display("test reset values done");
        set_en(8'h38, 8'h04);
        set_state(2'b10);
        set_state(2'b11);
        clear(8'h00, 8'h00);
        set_state(2'b01);
        set_lim(1'b1);
        clear(8'h20, 8'h00);
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            set_state(seed[1:0]);
            set_lim(seed[2]);
            if (seed[3]) clear(seed[15:8] & 8'h38, seed[23:16] & 8'h04);
            if (seed[4]) set_en(seed[31:24] & 8'h38, seed[7:0] & 8'h04);
        end
        set_en(8'h00, 8'h00);
        set_state(cur ^ 2'b10);
        set_en(8'h10, 8'h04);
        clear(8'h38, 8'h04);
        $display("test latched flags done");
        for (int i = 0; i < 4; i++) begin
            snap(1'b0);
            snap(1'b1);
        end
        $display("test snapshots done");
        set_state(2'b11);
        @(negedge clk_in);
        firmware_mismatch_in = 1'b1;
        @(negedge clk_in);
        firmware_mismatch_in = 1'b0;
        cycles(6);
        check(wont_run_flag_out, 1'b1, "wont run");
        check(tracking_flag_out, 1'b0, "free run tracking");
        check(loss_of_lock_flag_out, 1'b0, "free run lol");
        rd_chk(8'h57, {3'b000, 1'b1, 1'b0, lim, 2'b00});
        @(negedge clk_in);
        rst_in = 1'b1;
        cycles(2);
        rst_in = 1'b0;
        check(wont_run_flag_out, 1'b0, "wont run reset");
        rd_chk(8'h5b, 8'h00);
        $display("test wont run done");
        report_and_stop();
    end
endmodule
`default_nettype wire
